// >>> tmr_status_defs.vh
// register map, field positions and reset values of the status-flag block
`ifndef TMR_STATUS_DEFS_VH
`define TMR_STATUS_DEFS_VH

`define OFS_STATUS      4'h0
`define OFS_CONTROL     4'h4
`define OFS_IRQ_STATUS  4'h8
`define OFS_IRQ_MASK    4'hc

`define BIT_FLAG_A      0
`define BIT_FLAG_B      1
`define BIT_OVF         4
`define BIT_UNF         5
`define BIT_DIR         7
`define BIT_TRIG_EN     0

`define STATUS_RESET    8'hc0
`define STATUS_FIXED    8'h40
`define CNT_MAX         16'hffff
`define CNT_MIN         16'h0000

`define EV_FLAG_A       0
`define EV_FLAG_B       1
`define EV_OVF          2
`define EV_UNF          3
`define EV_WIDTH        4

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// >>> event_sync.v
// three-stage synchroniser with agreement check and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module event_sync (
    input  wire ref_clk,
    input  wire sys_rst,
    input  wire din,
    output reg  rise
);
    reg s1;
    reg s2;
    reg s3;
    reg level;

    // first stage read only by second; level moves when stages agree
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            s1   <= din;
            s2   <= s1;
            s3   <= s2;
            rise <= 1'b0;
            if (s2 == s3) begin
                level <= s3;
                rise  <= s3 & ~level;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tmr_status.v
// status flags of one 16-bit timer channel with an axi4-lite slave
//
// How it works
// R1: trigger enable gates converter start request
// R2: direction flag read-only, 1=up, resets 1
// R3: underflow set on wrap 0000 to ffff
// R4: underflow cleared by 0 after read 1
// R5: overflow set on wrap ffff to 0000
// R6: overflow cleared by 0 after read 1
// R7: flag a set on compare match
// R8: flag a set on input capture
// R9: transfer controller clears flag a unless retain
// R10: flag a cleared by 0 after read 1
// R11: flag b set on match or capture
// R12: flag b cleared by controller or software
// R13: writing 1 to a flag does nothing
// R14: set beats clear in same cycle
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_status_defs.vh"
module tmr_status (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire [15:0] channel_counter,
    input  wire        count_up,
    input  wire        cnt_tick,
    input  wire [15:0] general_register_a,
    input  wire [15:0] general_register_b,
    input  wire        capture_mode_a,
    input  wire        capture_mode_b,
    input  wire        capture_pin_a,
    input  wire        capture_pin_b,
    input  wire        xfer_ack_a,
    input  wire        xfer_ack_b,
    input  wire        interrupt_retain_select,
    output reg         converter_start,
    output wire        match_capture_irq_a,
    output wire        match_capture_irq_b,
    output wire        irq,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    reg                    flag_a;
    reg                    flag_b;
    reg                    overflow_flag;
    reg                    underflow_flag;
    reg                    count_direction_flag;
    reg                    seen_a;
    reg                    seen_b;
    reg                    seen_ovf;
    reg                    seen_unf;
    reg                    converter_trigger_enable;
    reg [`EV_WIDTH-1:0]    irq_status;
    reg [`EV_WIDTH-1:0]    irq_mask;
    reg [15:0]             prev_cnt;
    reg                    prev_valid;
    reg                    aw_held;
    reg                    w_held;
    reg [3:0]              aw_addr;
    reg [31:0]             w_data;
    reg [3:0]              w_strb;
    wire                   cap_a;
    wire                   cap_b;
    wire                   match_a;
    wire                   match_b;
    wire                   set_a;
    wire                   set_b;
    wire                   set_ovf;
    wire                   set_unf;
    wire                   wr_fire;
    wire                   rd_fire;
    wire                   wr_status;
    wire                   rd_status;
    wire [7:0]             status_byte;
    wire [`EV_WIDTH-1:0]   events;
    localparam [7:0]       status_reset_image = `STATUS_RESET;

    // status register image
    function [7:0] pack_status;
        input d;
        input u;
        input v;
        input b;
        input a;
        begin
            pack_status = `STATUS_FIXED;
            pack_status[`BIT_DIR]    = d;
            pack_status[`BIT_UNF]    = u;
            pack_status[`BIT_OVF]    = v;
            pack_status[`BIT_FLAG_B] = b;
            pack_status[`BIT_FLAG_A] = a;
        end
    endfunction

    // match of counter with a general register on a counter step
    function hit;
        input [15:0] cnt;
        input [15:0] gr;
        input        tick;
        begin
            hit = tick & (cnt == gr);
        end
    endfunction

    // capture inputs from pins
    event_sync sync_a (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     (capture_pin_a),
        .rise    (cap_a)
    );
    event_sync sync_b (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     (capture_pin_b),
        .rise    (cap_b)
    );

    // event detection
    assign match_a = hit(channel_counter, general_register_a, cnt_tick);
    assign match_b = hit(channel_counter, general_register_b, cnt_tick);
    assign set_a   = capture_mode_a ? cap_a : match_a;   // [R7] [R8]
    assign set_b   = capture_mode_b ? cap_b : match_b;   // [R11]
    assign set_ovf = prev_valid & (prev_cnt == `CNT_MAX)
                   & (channel_counter == `CNT_MIN);       // [R5]
    assign set_unf = prev_valid & (prev_cnt == `CNT_MIN)
                   & (channel_counter == `CNT_MAX);       // [R3]
    assign events  = {set_unf, set_ovf, set_b, set_a};

    // previous counter value for wrap detection
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_cnt   <= `CNT_MIN;
            prev_valid <= 1'b0;
        end else begin
            prev_cnt   <= channel_counter;
            prev_valid <= 1'b1;
        end
    end

    // axi handshakes: one write and one read at a time
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_fire   = aw_held & w_held & ~s_axi_bvalid;
    assign rd_fire   = s_axi_arvalid & s_axi_arready;
    assign wr_status = wr_fire & (aw_addr == `OFS_STATUS) & w_strb[0];
    assign rd_status = rd_fire & (s_axi_araddr == `OFS_STATUS);
    assign status_byte = pack_status(count_direction_flag, underflow_flag,
                                     overflow_flag, flag_b, flag_a);

    // write address and data capture
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response and control registers
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid             <= 1'b0;
            s_axi_bresp              <= `RESP_OKAY;
            converter_trigger_enable <= 1'b0;
            irq_mask                 <= {`EV_WIDTH{1'b0}};
        end else begin
            if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_addr)
                    `OFS_STATUS, `OFS_IRQ_STATUS: ;
                    `OFS_CONTROL: begin
                        if (w_strb[0])
                            converter_trigger_enable <=
                                w_data[`BIT_TRIG_EN];
                    end
                    `OFS_IRQ_MASK: begin
                        if (w_strb[0])
                            irq_mask <= w_data[`EV_WIDTH-1:0];
                    end
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
        end
    end

    // flags: read-as-1 arms, write 0 clears, set wins
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_a         <= 1'b0;
            flag_b         <= 1'b0;
            overflow_flag  <= 1'b0;
            underflow_flag <= 1'b0;
            seen_a         <= 1'b0;
            seen_b         <= 1'b0;
            seen_ovf       <= 1'b0;
            seen_unf       <= 1'b0;
        end else begin
            if (rd_status) begin
                seen_a   <= flag_a;
                seen_b   <= flag_b;
                seen_ovf <= overflow_flag;
                seen_unf <= underflow_flag;
            end
            // a written 1 leaves the flag alone
            if (wr_status & ~w_data[`BIT_FLAG_A] & seen_a) begin // [R10] [R13]
                flag_a <= 1'b0;
                seen_a <= 1'b0;
            end
            if (xfer_ack_a & ~interrupt_retain_select)
                flag_a <= 1'b0;                            // [R9]
            if (set_a)
                flag_a <= 1'b1;                            // [R14]
            if (wr_status & ~w_data[`BIT_FLAG_B] & seen_b) begin // [R12]
                flag_b <= 1'b0;
                seen_b <= 1'b0;
            end
            if (xfer_ack_b & ~interrupt_retain_select)
                flag_b <= 1'b0;                            // [R12]
            if (set_b)
                flag_b <= 1'b1;                            // [R14]
            if (wr_status & ~w_data[`BIT_OVF] & seen_ovf) begin // [R6]
                overflow_flag <= 1'b0;
                seen_ovf      <= 1'b0;
            end
            if (set_ovf)
                overflow_flag <= 1'b1;                     // [R14]
            if (wr_status & ~w_data[`BIT_UNF] & seen_unf) begin // [R4]
                underflow_flag <= 1'b0;
                seen_unf       <= 1'b0;
            end
            if (set_unf)
                underflow_flag <= 1'b1;                    // [R14]
        end
    end

    // direction flag follows counter, no write path
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            count_direction_flag <= status_reset_image[`BIT_DIR]; // [R2]
        else
            count_direction_flag <= count_up;              // [R2]
    end

    // converter start request on flag a event when enabled
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            converter_start <= 1'b0;
        else
            converter_start <= converter_trigger_enable & set_a; // [R1]
    end

    // interrupt status, cleared by read, set wins
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            irq_status <= {`EV_WIDTH{1'b0}};
        else if (rd_fire & (s_axi_araddr == `OFS_IRQ_STATUS))
            irq_status <= events;
        else
            irq_status <= irq_status | events;
    end

    assign irq                 = |(irq_status & irq_mask);
    assign match_capture_irq_a = flag_a;
    assign match_capture_irq_b = flag_b;

    // read data channel
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                case (s_axi_araddr)
                    `OFS_STATUS:     s_axi_rdata[7:0] <= status_byte;
                    `OFS_CONTROL:    s_axi_rdata[`BIT_TRIG_EN] <=
                                         converter_trigger_enable;
                    `OFS_IRQ_STATUS: s_axi_rdata[`EV_WIDTH-1:0] <= irq_status;
                    `OFS_IRQ_MASK:   s_axi_rdata[`EV_WIDTH-1:0] <= irq_mask;
                    default:         s_axi_rresp <= `RESP_SLVERR;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> placeholder_unused.v
// empty compile unit kept minimal
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> tmr_status_monitor.sv
// port assertions for the timer status-flag block
`timescale 1ns/1ps
`default_nettype none
module tmr_status_monitor (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [15:0] channel_counter,
    input wire logic        cnt_tick,
    input wire logic [15:0] general_register_a,
    input wire logic [15:0] general_register_b,
    input wire logic        capture_mode_a,
    input wire logic        capture_mode_b,
    input wire logic        xfer_ack_a,
    input wire logic        xfer_ack_b,
    input wire logic        interrupt_retain_select,
    input wire logic        converter_start,
    input wire logic        match_capture_irq_a,
    input wire logic        match_capture_irq_b,
    input wire logic        s_axi_bvalid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // compare hits and the transfer-controller cause of flag a falling
    wire hit_a = cnt_tick && !capture_mode_a
        && channel_counter == general_register_a;
    wire hit_b = cnt_tick && !capture_mode_b
        && channel_counter == general_register_b;
    // a software clear lands on the edge where bvalid rises
    wire drop = xfer_ack_a && !interrupt_retain_select;

    a_match_sets_a: assert property (
        hit_a |=> match_capture_irq_a) else $error("flag a missed match");
    a_match_sets_b: assert property (
        hit_b |=> match_capture_irq_b) else $error("flag b missed match");
    a_set_beats_ack: assert property (
        hit_a && xfer_ack_a |=> match_capture_irq_a)
        else $error("clear won over set");
    a_trig_with_flag: assert property (
        converter_start |-> match_capture_irq_a)
        else $error("start request without flag a");
    a_ack_clears_a: assert property (
        drop && !capture_mode_a && !hit_a |=> !match_capture_irq_a)
        else $error("flag a kept after transfer");
    a_retain_keeps_a: assert property (
        xfer_ack_a && interrupt_retain_select && match_capture_irq_a
        |=> match_capture_irq_a || $rose(s_axi_bvalid))
        else $error("flag a lost while retained");
    a_ack_clears_b: assert property (
        xfer_ack_b && !interrupt_retain_select && !capture_mode_b && !hit_b
        |=> !match_capture_irq_b) else $error("flag b kept after transfer");
    a_fall_has_cause: assert property (
        $fell(match_capture_irq_a) |-> $past(drop) || $rose(s_axi_bvalid))
        else $error("flag a fell without a clear");
endmodule

bind tmr_status tmr_status_monitor i_tmr_status_monitor (.ref_clk, .sys_rst,
    .channel_counter, .cnt_tick, .general_register_a, .general_register_b,
    .capture_mode_a, .capture_mode_b, .xfer_ack_a, .xfer_ack_b,
    .interrupt_retain_select, .converter_start, .match_capture_irq_a,
    .match_capture_irq_b, .s_axi_bvalid);
`default_nettype wire

// >>> xfer_ctrl_model.sv
// transfer controller model answering one flag interrupt
`timescale 1ns/1ps
`default_nettype none
module xfer_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic en,
    input  wire logic slow,
    input  wire logic irq_in,
    output var  logic ack
);
    logic [2:0] wait_cnt;
    // one-cycle activations, repeated while the interrupt stays raised, prompt or late
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack      <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (en && irq_in && !ack && (!slow || wait_cnt == 3'h4)) begin
            ack      <= 1'b1;
            wait_cnt <= 3'h0;
        end else begin
            ack      <= 1'b0;
            wait_cnt <= irq_in ? wait_cnt + 3'h1 : 3'h0;
        end
    end
endmodule
`default_nettype wire

// >>> tmr_status_tb_top.sv
// self-checking bench for the timer status-flag block
`timescale 1ns/1ps
`default_nettype none
module tmr_status_tb_top;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, count_up = 1'b1;
    logic [15:0] channel_counter = 16'h1234;
    logic [15:0] general_register_a, general_register_b;
    logic        cnt_tick = 1'b0, capture_mode_a = 1'b0, capture_mode_b = 1'b0;
    logic        capture_pin_a = 1'b0, capture_pin_b = 1'b0, en = 1'b0;
    logic        interrupt_retain_select = 1'b0, slow = 1'b0;
    logic        xfer_ack_a, xfer_ack_b, converter_start, irq;
    logic        match_capture_irq_a, match_capture_irq_b;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_total = 0, n_tests = 0, n_start = 0, k;

    tmr_status i_tmr_status (.ref_clk, .sys_rst, .channel_counter, .count_up,
        .cnt_tick, .general_register_a, .general_register_b, .capture_mode_a,
        .capture_mode_b, .capture_pin_a, .capture_pin_b, .xfer_ack_a,
        .xfer_ack_b, .interrupt_retain_select, .converter_start,
        .match_capture_irq_a, .match_capture_irq_b, .irq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    xfer_ctrl_model i_ack_a (.ref_clk, .sys_rst, .en, .slow,
        .irq_in(match_capture_irq_a), .ack(xfer_ack_a));
    xfer_ctrl_model i_ack_b (.ref_clk, .sys_rst, .en, .slow,
        .irq_in(match_capture_irq_b), .ack(xfer_ack_b));

    always #12.5 ref_clk = ~ref_clk;
    // counts converter start pulses
    always @(posedge ref_clk) begin
        if (converter_start === 1'b1)
            n_start <= n_start + 1;
    end

    // expected status word: direction, {unf,ovf}, {b,a}
    function automatic logic [31:0] st(input logic d, input logic [1:0] uv,
                                       input logic [1:0] ba);
        st = {24'h0, d, 1'b1, uv, 2'b00, ba};
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        integer i;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 40; i = i + 1) begin
            @(posedge ref_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                chk(s_axi_bresp, 2'b00);
                s_axi_bready <= 1'b0;
                i = 99;
            end
        end
        if (i == 40) begin
            err_total = err_total + 1;
            print_verdict;
        end
    endtask

    task rd(input logic [3:0] a, output logic [31:0] d);
        integer i;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 40; i = i + 1) begin
            @(posedge ref_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                s_axi_rready <= 1'b0;
                i = 99;
            end
        end
        if (i == 40) begin
            err_total = err_total + 1;
            print_verdict;
        end
    endtask

    // one counter step onto a compare value
    task hit(input logic b);
        @(posedge ref_clk);
        channel_counter <= b ? general_register_b : general_register_a;
        cnt_tick <= 1'b1;
        @(posedge ref_clk);
        cnt_tick <= 1'b0;
        channel_counter <= 16'h1234;
        repeat (2) @(posedge ref_clk);
    endtask

    initial begin
        k = $urandom(32'h8313172d);
        v = 32'h2000 + $urandom % 32'hc000;
        general_register_a <= v[15:0];
        general_register_b <= v[15:0] ^ 16'h0001;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(4'h0, v);
        chk(v, st(1'b1, 2'b00, 2'b00));
        count_up <= 1'b0;
        wr(4'h0, 32'hff);
        rd(4'h0, v);
        chk(v, st(1'b0, 2'b00, 2'b00));
        wr(4'hc, 32'hf);
        // wrap down then up; a write before any read must not clear
        for (k = 0; k < 2; k = k + 1) begin
            @(posedge ref_clk);
            count_up <= k[0];
            channel_counter <= k[0] ? 16'hffff : 16'h0000;
            @(posedge ref_clk);
            channel_counter <= k[0] ? 16'h0000 : 16'hffff;
            @(posedge ref_clk);
            channel_counter <= 16'h1234;
            wr(4'h0, 32'h0);
            rd(4'h0, v);
            chk(v, st(k[0], k[0] ? 2'b01 : 2'b10, 2'b00));
            chk(irq, 1'b1);
            rd(4'h8, v);
            chk(v, k[0] ? 32'h4 : 32'h8);
            chk(irq, 1'b0);
            wr(4'h0, 32'h0);
            rd(4'h0, v);
            chk(v, st(k[0], 2'b00, 2'b00));
        end
        // compare a with the start request enabled, then disabled
        wr(4'hc, 32'h0);
        for (k = 0; k < 2; k = k + 1) begin
            wr(4'h4, {31'h0, !k[0]});
            n_start = 0;
            hit(1'b0);
            chk(n_start, k[0] ? 0 : 1);
            chk(irq, 1'b0);
            rd(4'h0, v);
            chk(v, st(1'b1, 2'b00, 2'b01));
            wr(4'h0, 32'h0);
            chk(match_capture_irq_a, 1'b0);
        end
        // software clear racing a new match
        hit(1'b0);
        rd(4'h0, v);
        fork
            wr(4'h0, 32'h0);
            begin
                @(posedge ref_clk); // match lands on the clearing edge
                hit(1'b0);
            end
        join
        chk(match_capture_irq_a, 1'b1);
        hit(1'b1);
        rd(4'h0, v);
        chk(v, st(1'b1, 2'b00, 2'b11));
        wr(4'h0, 32'h1);
        chk({match_capture_irq_b, match_capture_irq_a}, 2'b01);
        hit(1'b1);
        // slow controller: retained first, then cleared
        interrupt_retain_select <= 1'b1;
        en <= 1'b1;
        slow <= 1'b1;
        repeat (12) @(posedge ref_clk);
        chk({match_capture_irq_b, match_capture_irq_a}, 2'b11);
        interrupt_retain_select <= 1'b0;
        repeat (12) @(posedge ref_clk);
        chk({match_capture_irq_b, match_capture_irq_a}, 2'b00);
        // capture on both registers, then a prompt controller
        en <= 1'b0;
        slow <= 1'b0;
        capture_mode_a <= 1'b1;
        capture_mode_b <= 1'b1;
        @(posedge ref_clk);
        capture_pin_a <= 1'b1;
        capture_pin_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        capture_pin_a <= 1'b0;
        capture_pin_b <= 1'b0;
        rd(4'h0, v);
        chk(v, st(1'b1, 2'b00, 2'b11));
        en <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({match_capture_irq_b, match_capture_irq_a}, 2'b00);
        // a match in the very cycle the controller clears flag a
        capture_mode_a <= 1'b0;
        @(posedge ref_clk);
        channel_counter <= general_register_a;
        cnt_tick <= 1'b1;
        repeat (3) @(posedge ref_clk);
        cnt_tick <= 1'b0;
        channel_counter <= 16'h1234;
        @(posedge ref_clk);
        chk(match_capture_irq_a, 1'b1);
        repeat (3) @(posedge ref_clk);
        chk(match_capture_irq_a, 1'b0);
        print_verdict;
    end
endmodule
`default_nettype wire
